// File: hw/aig_pkg.sv
// Register map, field positions and reset values for the audio input gain control registers.
package aig_pkg;
	localparam int ADDR_W = 12;
	localparam logic [11:0] OFS_CNT_LO = 12'hb28;
	localparam logic [11:0] OFS_CNT_HI = 12'hb29;
	localparam logic [11:0] OFS_FILL_MODE = 12'hb2c;
	localparam logic [11:0] OFS_WORD_B0 = 12'hb30;
	localparam logic [11:0] OFS_WORD_B1 = 12'hb31;
	localparam logic [11:0] OFS_WORD_B2 = 12'hb32;
	localparam logic [11:0] OFS_WORD_B3 = 12'hb33;
	localparam logic [11:0] OFS_CONV_OPT = 12'hb35;
	localparam logic [11:0] OFS_CAL_MUL = 12'hb36;
	localparam logic [11:0] OFS_CAL_BIAS = 12'hb37;
	localparam logic [11:0] OFS_FILTER = 12'hb40;
	localparam logic [11:0] OFS_LVL_L = 12'hb41;
	localparam logic [11:0] OFS_LVL_R = 12'hb42;
	localparam logic [11:0] OFS_MAX_GAIN = 12'hb43;
	localparam logic [11:0] OFS_HI_TGT = 12'hb44;
	localparam logic [11:0] OFS_LO_TGT = 12'hb46;
	localparam logic [11:0] OFS_NOISE = 12'hb48;
	localparam logic [11:0] OFS_GSTAT_L = 12'hb4d;
	localparam logic [11:0] OFS_GSTAT_R = 12'hb4e;
	localparam logic [11:0] OFS_TICK_LO = 12'hb50;
	localparam logic [11:0] OFS_TICK_HI = 12'hb51;
	localparam logic [11:0] OFS_MODE = 12'hb54;
	localparam logic [11:0] OFS_COEF = 12'hb55;
	localparam logic [11:0] OFS_MASK_CNT = 12'hb56;
	localparam logic [11:0] OFS_RISE_RATE = 12'hb57;
	localparam logic [11:0] OFS_RISE_MAX = 12'hb58;
	localparam logic [11:0] OFS_FALL_RATE = 12'hb59;
	localparam logic [11:0] OFS_FALL_MAX = 12'hb5a;
	localparam logic [11:0] OFS_NFALL_RATE = 12'hb5b;
	localparam logic [11:0] OFS_NFALL_MAX = 12'hb5c;
	localparam logic [11:0] OFS_AMP_A = 12'hb5e;
	localparam logic [11:0] OFS_AMP_B = 12'hb5f;
	localparam logic [11:0] OFS_JUDGE = 12'hb60;
	localparam logic [11:0] OFS_TGT_L = 12'hb61;
	localparam logic [11:0] OFS_VAL_L = 12'hb62;
	localparam logic [11:0] OFS_FIX = 12'hb63;
	localparam logic [11:0] OFS_SWAP = 12'hb64;
	localparam logic [11:0] OFS_TGT_R = 12'hb65;
	localparam logic [11:0] OFS_VAL_R = 12'hb66;
	// Reset values.
	localparam logic [7:0] RST_ZERO = 8'h00;
	localparam logic [7:0] RST_CONV_OPT = 8'h09;
	localparam logic [7:0] RST_FILTER = 8'hfb;
	localparam logic [7:0] RST_LVL = 8'h20;
	localparam logic [7:0] RST_MAX_GAIN = 8'h33;
	localparam logic [7:0] RST_HI_TGT = 8'h60;
	localparam logic [7:0] RST_LO_TGT = 8'h40;
	localparam logic [7:0] RST_NOISE = 8'h02;
	localparam logic [7:0] RST_TICK_HI = 8'h02;
	localparam logic [7:0] RST_MODE = 8'h0a;
	localparam logic [7:0] RST_COEF = 8'hfa;
	localparam logic [7:0] RST_RISE_RATE = 8'h0a;
	localparam logic [7:0] RST_RISE_MAX = 8'h03;
	localparam logic [7:0] RST_FALL_RATE = 8'h08;
	localparam logic [7:0] RST_FALL_MAX = 8'h06;
	localparam logic [7:0] RST_NFALL = 8'h06;
	localparam logic [7:0] RST_JUDGE = 8'h40;
	localparam logic [7:0] RST_FIX = 8'h80;
	// Field positions.
	localparam int BIT_MANUAL_FILL = 0;
	localparam int BIT_SWAP_IN = 4;
	localparam int BIT_AUTO = 7;
	localparam int BIT_MUTE = 7;
	localparam int BIT_FIX_EN = 7;
	localparam int BIT_SWAP_AMP = 0;
	localparam int BIT_ANALOG = 0;
	localparam int BIT_IIR_CLR = 3;
	localparam int BIT_HPF_BYP = 4;
	localparam int BIT_LVL_BYP = 5;
	localparam int BIT_LPF_BYP = 6;
	localparam logic [6:0] GAIN_ZERO = 7'h00;
	localparam logic [3:0] MASK_ZERO = 4'h0;
	localparam logic [15:0] TICK_ONE = 16'h0001;
endpackage : aig_pkg

// File: hw/aig_regs.sv
// Audio input gain control register bank with the automatic amplifier gain stepper.
// What this block does
// RL1: Fill mode bit selects automatic or manual fill.
// RL2: Four byte writes build one manual word.
// RL3: Sixteen-bit word count readable as two bytes.
// RL4: Option bit four swaps input channels.
// RL5: Holds converter options, multiplier and bias.
// RL6: Filter bits bypass stages, tune, double downsample.
// RL7: Per-channel bit seven picks auto level control.
// RL8: Manual gain low six; auto minimum seven.
// RL9: Auto gain never exceeds the maximum limit.
// RL10: Targets coded dB: fraction bit, integer bits.
// RL11: Status reads gain in auto, volume manual.
// RL12: Sixteen-bit tick period paces peak tracking.
// RL13: Mode bits and smoothing coefficient register.
// RL14: Samples masked after each gain change.
// RL15: Gain rises at rate, capped per tick.
// RL16: Gain falls at rate, capped per tick.
// RL17: Noise uses its own fall rate and cap.
// RL18: Current amplifier gain readable in auto mode.
// RL19: Judge speed, manual targets with done flags.
// RL20: Value register reads value, mute writes mute.
// RL21: Fix enable applies the programmed fixed gain.
// RL22: Swap bit exchanges amplifier channels.
// RL23: Software clears analog and auto for digital manual.
// RL24: Settings act on the next processed sample; the gain limit, fix, swap and mute act without waiting for a sample.
//
// The strobed register port was left to the implementer.
`timescale 1ns/1ns
module aig_regs (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic [11:0] regAddr,
	input wire logic [7:0] regWrData,
	input wire logic regWrite,
	input wire logic regRead,
	output logic [7:0] regRdData,
	input wire logic [15:0] fifoCount,
	output logic manualFill,
	output logic [31:0] manualWord,
	output logic manualWordValid,
	output logic [7:0] converterOptions,
	output logic [7:0] calMultiplier,
	output logic [7:0] calBias,
	output logic [7:0] filterControl,
	output logic [7:0] levelSettingLeft,
	output logic [7:0] levelSettingRight,
	output logic [7:0] volumeTargets,
	output logic [7:0] modeEnables,
	output logic [7:0] smoothingCoef,
	output logic [15:0] tickPeriod,
	output logic [7:0] judgeSpeed,
	input wire logic sampleStrobe,
	input wire logic peakHigh,
	input wire logic peakLow,
	input wire logic peakNoise,
	input wire logic [7:0] volumeLeft,
	input wire logic [7:0] volumeRight,
	input wire logic [1:0] judgeDone,
	input wire logic [6:0] manualValueLeft,
	input wire logic [6:0] manualValueRight,
	output logic [6:0] ampGainLeft,
	output logic [6:0] ampGainRight,
	output logic ampMuteLeft,
	output logic ampMuteRight,
	output logic sampleMask
);

	// Plain software-written control bytes, one flip-flop group per register.
	logic [7:0] fillMode_r, fillMode_nxt, conv_r, conv_nxt, mul_r, mul_nxt, bias_r, bias_nxt;
	logic [7:0] filt_r, filt_nxt, lvlL_r, lvlL_nxt, lvlR_r, lvlR_nxt, maxG_r, maxG_nxt;
	logic [7:0] hiT_r, hiT_nxt, loT_r, loT_nxt, noise_r, noise_nxt, tLo_r, tLo_nxt;
	logic [7:0] tHi_r, tHi_nxt, mode_r, mode_nxt, coef_r, coef_nxt, mskN_r, mskN_nxt;
	logic [7:0] rRate_r, rRate_nxt, rMax_r, rMax_nxt, fRate_r, fRate_nxt, fMax_r, fMax_nxt;
	logic [7:0] nRate_r, nRate_nxt, nMax_r, nMax_nxt, judge_r, judge_nxt, tgtL_r, tgtL_nxt;
	logic [7:0] tgtR_r, tgtR_nxt, fix_r, fix_nxt, swap_r, swap_nxt;
	logic muteL_r, muteL_nxt, muteR_r, muteR_nxt;
	logic [31:0] word_r, word_nxt;
	logic wordValid_r, wordValid_nxt;
	logic [7:0] rd_r, rd_nxt;

	// Returns true when the address equals the given offset; callers gate it with the write strobe.
	function automatic logic hit(input logic [11:0] a, input logic [11:0] ofs);
		hit = (a == ofs);
	endfunction : hit

	// Replaces a byte when the write hits its offset, otherwise holds it.
	function automatic logic [7:0] upd(input logic wr, input logic [11:0] a,
		input logic [11:0] ofs, input logic [7:0] d, input logic [7:0] old);
		upd = (wr && hit(a, ofs)) ? d : old;
	endfunction : upd

	// Register writes; in manual fill the manual word goes out when its top byte lands.
	always_comb begin
		fillMode_nxt = upd(regWrite, regAddr, aig_pkg::OFS_FILL_MODE, regWrData, fillMode_r); // [RL1]
		conv_nxt = upd(regWrite, regAddr, aig_pkg::OFS_CONV_OPT, regWrData, conv_r); // [RL5]
		mul_nxt = upd(regWrite, regAddr, aig_pkg::OFS_CAL_MUL, regWrData, mul_r);
		bias_nxt = upd(regWrite, regAddr, aig_pkg::OFS_CAL_BIAS, regWrData, bias_r);
		filt_nxt = upd(regWrite, regAddr, aig_pkg::OFS_FILTER, regWrData, filt_r); // [RL6]
		lvlL_nxt = upd(regWrite, regAddr, aig_pkg::OFS_LVL_L, regWrData, lvlL_r); // [RL7]
		lvlR_nxt = upd(regWrite, regAddr, aig_pkg::OFS_LVL_R, regWrData, lvlR_r);
		maxG_nxt = upd(regWrite, regAddr, aig_pkg::OFS_MAX_GAIN, regWrData, maxG_r);
		hiT_nxt = upd(regWrite, regAddr, aig_pkg::OFS_HI_TGT, regWrData, hiT_r); // [RL10]
		loT_nxt = upd(regWrite, regAddr, aig_pkg::OFS_LO_TGT, regWrData, loT_r);
		noise_nxt = upd(regWrite, regAddr, aig_pkg::OFS_NOISE, regWrData, noise_r);
		tLo_nxt = upd(regWrite, regAddr, aig_pkg::OFS_TICK_LO, regWrData, tLo_r); // [RL12]
		tHi_nxt = upd(regWrite, regAddr, aig_pkg::OFS_TICK_HI, regWrData, tHi_r);
		mode_nxt = upd(regWrite, regAddr, aig_pkg::OFS_MODE, regWrData, mode_r); // [RL13]
		coef_nxt = upd(regWrite, regAddr, aig_pkg::OFS_COEF, regWrData, coef_r);
		mskN_nxt = upd(regWrite, regAddr, aig_pkg::OFS_MASK_CNT, regWrData, mskN_r);
		rRate_nxt = upd(regWrite, regAddr, aig_pkg::OFS_RISE_RATE, regWrData, rRate_r);
		rMax_nxt = upd(regWrite, regAddr, aig_pkg::OFS_RISE_MAX, regWrData, rMax_r);
		fRate_nxt = upd(regWrite, regAddr, aig_pkg::OFS_FALL_RATE, regWrData, fRate_r);
		fMax_nxt = upd(regWrite, regAddr, aig_pkg::OFS_FALL_MAX, regWrData, fMax_r);
		nRate_nxt = upd(regWrite, regAddr, aig_pkg::OFS_NFALL_RATE, regWrData, nRate_r);
		nMax_nxt = upd(regWrite, regAddr, aig_pkg::OFS_NFALL_MAX, regWrData, nMax_r);
		judge_nxt = upd(regWrite, regAddr, aig_pkg::OFS_JUDGE, regWrData, judge_r); // [RL19]
		tgtL_nxt = upd(regWrite, regAddr, aig_pkg::OFS_TGT_L, regWrData, tgtL_r);
		tgtR_nxt = upd(regWrite, regAddr, aig_pkg::OFS_TGT_R, regWrData, tgtR_r);
		fix_nxt = upd(regWrite, regAddr, aig_pkg::OFS_FIX, regWrData, fix_r);
		swap_nxt = upd(regWrite, regAddr, aig_pkg::OFS_SWAP, regWrData, swap_r);
		muteL_nxt = muteL_r;
		muteR_nxt = muteR_r;
		if (regWrite && hit(regAddr, aig_pkg::OFS_VAL_L)) begin
			muteL_nxt = regWrData[aig_pkg::BIT_MUTE]; // [RL20]
		end
		if (regWrite && hit(regAddr, aig_pkg::OFS_VAL_R)) begin
			muteR_nxt = regWrData[aig_pkg::BIT_MUTE]; // [RL20]
		end
		word_nxt = word_r;
		wordValid_nxt = 1'b0;
		if (regWrite && hit(regAddr, aig_pkg::OFS_WORD_B0)) begin
			word_nxt[7:0] = regWrData; // [RL2]
		end
		if (regWrite && hit(regAddr, aig_pkg::OFS_WORD_B1)) begin
			word_nxt[15:8] = regWrData; // [RL2]
		end
		if (regWrite && hit(regAddr, aig_pkg::OFS_WORD_B2)) begin
			word_nxt[23:16] = regWrData; // [RL2]
		end
		if (regWrite && hit(regAddr, aig_pkg::OFS_WORD_B3)) begin
			word_nxt[31:24] = regWrData; // [RL2]
			// Words written while in automatic fill are held but never pushed.
			wordValid_nxt = fillMode_r[aig_pkg::BIT_MANUAL_FILL]; // [RL1]
		end
	end

	// Automatic level control state: gain and step per channel; tick, rate and mask counters shared.
	logic [6:0] gainL_r, gainL_nxt, gainR_r, gainR_nxt;
	logic [15:0] tick_r, tick_nxt;
	logic [7:0] rateCnt_r, rateCnt_nxt;
	logic [6:0] stepL_r, stepL_nxt, stepR_r, stepR_nxt;
	logic [3:0] mask_r, mask_nxt;
	logic autoL, autoR, rateHit, changed, newTick;
	logic [7:0] rateSel;

	// One gain step toward the targets, bounded by limits and per-tick budget.
	function automatic logic [6:0] stepGain(input logic [6:0] g, input logic [6:0] step,
		input logic hi, input logic lo, input logic nz, input logic [6:0] minG,
		input logic [6:0] maxG, input logic [6:0] rMax, input logic [6:0] fMax,
		input logic [6:0] nMax);
		stepGain = g;
		if (hi || nz) begin
			if (g > minG && step < (nz ? nMax : fMax)) begin
				stepGain = g - 7'h01; // [RL16] [RL17]
			end
		end else if (lo) begin
			if (g < maxG && step < rMax) begin
				stepGain = g + 7'h01; // [RL15] [RL9]
			end
		end
	endfunction : stepGain

	// Gain stepping runs on processed samples so register writes apply next sample.
	always_comb begin
		autoL = lvlL_r[aig_pkg::BIT_AUTO]; // [RL7]
		autoR = lvlR_r[aig_pkg::BIT_AUTO];
		rateSel = peakNoise ? nRate_r : (peakHigh ? fRate_r : rRate_r); // [RL17]
		rateHit = sampleStrobe && (rateCnt_r >= rateSel);
		// The wrap sample opens a new tick cycle, so its step is charged to the new budget.
		newTick = sampleStrobe && (tick_r >= {tHi_r, tLo_r}); // [RL12]
		tick_nxt = tick_r;
		rateCnt_nxt = rateCnt_r;
		stepL_nxt = newTick ? aig_pkg::GAIN_ZERO : stepL_r;
		stepR_nxt = newTick ? aig_pkg::GAIN_ZERO : stepR_r;
		gainL_nxt = gainL_r;
		gainR_nxt = gainR_r;
		mask_nxt = mask_r;
		if (sampleStrobe) begin // [RL24]
			rateCnt_nxt = rateHit ? 8'h00 : rateCnt_r + 8'h01;
			if (mask_r != aig_pkg::MASK_ZERO) begin
				mask_nxt = mask_r - 4'h1; // [RL14]
			end
			tick_nxt = newTick ? 16'h0000 : tick_r + aig_pkg::TICK_ONE; // [RL12]
		end
		if (rateHit && autoL) begin
			gainL_nxt = stepGain(gainL_r, stepL_nxt, peakHigh, peakLow, peakNoise, lvlL_r[6:0],
				maxG_r[6:0], rMax_r[6:0], fMax_r[6:0], nMax_r[6:0]); // [RL8] [RL9]
		end
		if (rateHit && autoR) begin
			gainR_nxt = stepGain(gainR_r, stepR_nxt, peakHigh, peakLow, peakNoise, lvlR_r[6:0],
				maxG_r[6:0], rMax_r[6:0], fMax_r[6:0], nMax_r[6:0]);
		end
		// A limit lowered by software pulls the gain back under it at once.
		if (gainL_nxt > maxG_r[6:0]) begin
			gainL_nxt = maxG_r[6:0]; // [RL9]
		end
		if (gainR_nxt > maxG_r[6:0]) begin
			gainR_nxt = maxG_r[6:0];
		end
		if (gainL_nxt != gainL_r) begin
			stepL_nxt = stepL_nxt + 7'h01; // [RL15] [RL16]
		end
		if (gainR_nxt != gainR_r) begin
			stepR_nxt = stepR_nxt + 7'h01;
		end
		changed = (gainL_nxt != gainL_r) || (gainR_nxt != gainR_r);
		if (changed) begin
			mask_nxt = mskN_r[3:0]; // [RL14]
		end
	end

	// Read mux; status bytes show the value current at the read strobe.
	always_comb begin
		rd_nxt = 8'h00;
		if (regRead) begin
			case (regAddr)
				aig_pkg::OFS_CNT_LO: rd_nxt = fifoCount[7:0]; // [RL3]
				aig_pkg::OFS_CNT_HI: rd_nxt = fifoCount[15:8]; // [RL3]
				aig_pkg::OFS_FILL_MODE: rd_nxt = fillMode_r;
				aig_pkg::OFS_CONV_OPT: rd_nxt = conv_r;
				aig_pkg::OFS_CAL_MUL: rd_nxt = mul_r;
				aig_pkg::OFS_CAL_BIAS: rd_nxt = bias_r;
				aig_pkg::OFS_FILTER: rd_nxt = filt_r;
				aig_pkg::OFS_LVL_L: rd_nxt = lvlL_r;
				aig_pkg::OFS_LVL_R: rd_nxt = lvlR_r;
				aig_pkg::OFS_MAX_GAIN: rd_nxt = maxG_r;
				aig_pkg::OFS_HI_TGT: rd_nxt = hiT_r;
				aig_pkg::OFS_LO_TGT: rd_nxt = loT_r;
				aig_pkg::OFS_NOISE: rd_nxt = noise_r;
				aig_pkg::OFS_GSTAT_L: rd_nxt = autoL ? {1'b0, gainL_r} : volumeLeft; // [RL11]
				aig_pkg::OFS_GSTAT_R: rd_nxt = autoR ? {1'b0, gainR_r} : volumeRight; // [RL11]
				aig_pkg::OFS_TICK_LO: rd_nxt = tLo_r;
				aig_pkg::OFS_TICK_HI: rd_nxt = tHi_r;
				aig_pkg::OFS_MODE: rd_nxt = mode_r;
				aig_pkg::OFS_COEF: rd_nxt = coef_r;
				aig_pkg::OFS_MASK_CNT: rd_nxt = mskN_r;
				aig_pkg::OFS_RISE_RATE: rd_nxt = rRate_r;
				aig_pkg::OFS_RISE_MAX: rd_nxt = rMax_r;
				aig_pkg::OFS_FALL_RATE: rd_nxt = fRate_r;
				aig_pkg::OFS_FALL_MAX: rd_nxt = fMax_r;
				aig_pkg::OFS_NFALL_RATE: rd_nxt = nRate_r;
				aig_pkg::OFS_NFALL_MAX: rd_nxt = nMax_r;
				aig_pkg::OFS_AMP_A: rd_nxt = {1'b0, gainL_r}; // [RL18]
				aig_pkg::OFS_AMP_B: rd_nxt = {1'b0, gainR_r}; // [RL18]
				aig_pkg::OFS_JUDGE: rd_nxt = judge_r;
				aig_pkg::OFS_TGT_L: rd_nxt = {judgeDone[0], tgtL_r[6:0]}; // [RL19]
				aig_pkg::OFS_TGT_R: rd_nxt = {judgeDone[1], tgtR_r[6:0]}; // [RL19]
				aig_pkg::OFS_VAL_L: rd_nxt = {muteL_r, manualValueLeft}; // [RL20]
				aig_pkg::OFS_VAL_R: rd_nxt = {muteR_r, manualValueRight}; // [RL20]
				aig_pkg::OFS_FIX: rd_nxt = fix_r;
				aig_pkg::OFS_SWAP: rd_nxt = swap_r;
				default: rd_nxt = 8'h00;
			endcase
		end
	end

	// All register state; reset takes constants only.
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			fillMode_r <= aig_pkg::RST_ZERO;
			conv_r <= aig_pkg::RST_CONV_OPT;
			mul_r <= aig_pkg::RST_ZERO;
			bias_r <= aig_pkg::RST_ZERO;
			filt_r <= aig_pkg::RST_FILTER;
			lvlL_r <= aig_pkg::RST_LVL;
			lvlR_r <= aig_pkg::RST_LVL;
			maxG_r <= aig_pkg::RST_MAX_GAIN;
			hiT_r <= aig_pkg::RST_HI_TGT;
			loT_r <= aig_pkg::RST_LO_TGT;
			noise_r <= aig_pkg::RST_NOISE;
			tLo_r <= aig_pkg::RST_ZERO;
			tHi_r <= aig_pkg::RST_TICK_HI;
			mode_r <= aig_pkg::RST_MODE;
			coef_r <= aig_pkg::RST_COEF;
			mskN_r <= aig_pkg::RST_ZERO;
			rRate_r <= aig_pkg::RST_RISE_RATE;
			rMax_r <= aig_pkg::RST_RISE_MAX;
			fRate_r <= aig_pkg::RST_FALL_RATE;
			fMax_r <= aig_pkg::RST_FALL_MAX;
			nRate_r <= aig_pkg::RST_NFALL;
			nMax_r <= aig_pkg::RST_NFALL;
			judge_r <= aig_pkg::RST_JUDGE;
			tgtL_r <= aig_pkg::RST_ZERO;
			tgtR_r <= aig_pkg::RST_ZERO;
			fix_r <= aig_pkg::RST_FIX;
			swap_r <= aig_pkg::RST_ZERO;
			muteL_r <= 1'b0;
			muteR_r <= 1'b0;
			word_r <= 32'h0000_0000;
			wordValid_r <= 1'b0;
			rd_r <= 8'h00;
			gainL_r <= aig_pkg::GAIN_ZERO;
			gainR_r <= aig_pkg::GAIN_ZERO;
			tick_r <= 16'h0000;
			rateCnt_r <= 8'h00;
			stepL_r <= aig_pkg::GAIN_ZERO;
			stepR_r <= aig_pkg::GAIN_ZERO;
			mask_r <= aig_pkg::MASK_ZERO;
		end else begin
			fillMode_r <= fillMode_nxt;
			conv_r <= conv_nxt;
			mul_r <= mul_nxt;
			bias_r <= bias_nxt;
			filt_r <= filt_nxt;
			lvlL_r <= lvlL_nxt;
			lvlR_r <= lvlR_nxt;
			maxG_r <= maxG_nxt;
			hiT_r <= hiT_nxt;
			loT_r <= loT_nxt;
			noise_r <= noise_nxt;
			tLo_r <= tLo_nxt;
			tHi_r <= tHi_nxt;
			mode_r <= mode_nxt;
			coef_r <= coef_nxt;
			mskN_r <= mskN_nxt;
			rRate_r <= rRate_nxt;
			rMax_r <= rMax_nxt;
			fRate_r <= fRate_nxt;
			fMax_r <= fMax_nxt;
			nRate_r <= nRate_nxt;
			nMax_r <= nMax_nxt;
			judge_r <= judge_nxt;
			tgtL_r <= tgtL_nxt;
			tgtR_r <= tgtR_nxt;
			fix_r <= fix_nxt;
			swap_r <= swap_nxt;
			muteL_r <= muteL_nxt;
			muteR_r <= muteR_nxt;
			word_r <= word_nxt;
			wordValid_r <= wordValid_nxt;
			rd_r <= rd_nxt;
			gainL_r <= gainL_nxt;
			gainR_r <= gainR_nxt;
			tick_r <= tick_nxt;
			rateCnt_r <= rateCnt_nxt;
			stepL_r <= stepL_nxt;
			stepR_r <= stepR_nxt;
			mask_r <= mask_nxt;
		end
	end

	// Outputs; the fixed gain overrides stepping, and swap crosses the channels.
	logic [6:0] effL, effR;
	logic swapAmp;
	always_comb begin
		effL = fix_r[aig_pkg::BIT_FIX_EN] ? fix_r[6:0] : gainL_r; // [RL21]
		effR = fix_r[aig_pkg::BIT_FIX_EN] ? fix_r[6:0] : gainR_r; // [RL21]
		swapAmp = swap_r[aig_pkg::BIT_SWAP_AMP];
	end
	assign ampGainLeft = swapAmp ? effR : effL; // [RL22]
	assign ampGainRight = swapAmp ? effL : effR; // [RL22]
	assign ampMuteLeft = swapAmp ? muteR_r : muteL_r;
	assign ampMuteRight = swapAmp ? muteL_r : muteR_r;
	assign sampleMask = (mask_r != aig_pkg::MASK_ZERO); // [RL14]
	assign regRdData = rd_r;
	assign manualFill = fillMode_r[aig_pkg::BIT_MANUAL_FILL]; // [RL1]
	assign manualWord = word_r;
	assign manualWordValid = wordValid_r;
	assign converterOptions = conv_r; // [RL4]
	assign calMultiplier = mul_r;
	assign calBias = bias_r;
	assign filterControl = filt_r; // [RL6]
	assign levelSettingLeft = lvlL_r;
	assign levelSettingRight = lvlR_r;
	assign volumeTargets = hiT_r ^ loT_r ^ noise_r;
	assign modeEnables = mode_r;
	assign smoothingCoef = coef_r;
	assign tickPeriod = {tHi_r, tLo_r};
	assign judgeSpeed = judge_r;

endmodule : aig_regs

// File: bench/aig_regs_properties.sv
// Concurrent checks on the register port and word outputs of the gain control bank.
`timescale 1ns/1ns
module aig_regs_checker (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic [11:0] regAddr,
	input wire logic [7:0] regWrData,
	input wire logic regWrite,
	input wire logic regRead,
	input wire logic [7:0] regRdData,
	input wire logic [15:0] fifoCount,
	input wire logic manualFill,
	input wire logic [31:0] manualWord,
	input wire logic manualWordValid,
	input wire logic [6:0] ampGainLeft
);
	// Every check runs on the one system clock and is quiet while reset is held.
	default clocking @(posedge clock); endclocking
	default disable iff (!rst_n);
	// A register access is a strobe and its address together in one cycle.
	sequence s_wr(a);
		regWrite && regAddr == a;
	endsequence
	sequence s_rd(a);
		regRead && regAddr == a;
	endsequence
	property p_rd_idle;
		!$past(regRead) |-> regRdData == 8'h00;
	endproperty
	a_rd_idle: assert property (p_rd_idle) else $error("read data not idle");
	property p_cnt_lo;
		s_rd(aig_pkg::OFS_CNT_LO) |=> regRdData == $past(fifoCount[7:0]);
	endproperty
	a_cnt_lo: assert property (p_cnt_lo) else $error("count low byte wrong");
	property p_cnt_hi;
		s_rd(aig_pkg::OFS_CNT_HI) |=> regRdData == $past(fifoCount[15:8]);
	endproperty
	a_cnt_hi: assert property (p_cnt_hi) else $error("count high byte wrong");
	property p_fill;
		s_wr(aig_pkg::OFS_FILL_MODE) |=> manualFill == $past(regWrData[0]);
	endproperty
	a_fill: assert property (p_fill) else $error("fill mode not taken");
	property p_word_emit;
		s_wr(aig_pkg::OFS_WORD_B3) ##0 manualFill
			|=> manualWordValid && manualWord[31:24] == $past(regWrData);
	endproperty
	a_word_emit: assert property (p_word_emit) else $error("manual word not emitted");
	property p_word_none;
		s_wr(aig_pkg::OFS_WORD_B3) ##0 !manualFill |=> !manualWordValid;
	endproperty
	a_word_none: assert property (p_word_none) else $error("word emitted in auto fill");
	property p_word_cause;
		manualWordValid |-> $past(regWrite) && $past(manualFill)
			&& $past(regAddr) == aig_pkg::OFS_WORD_B3;
	endproperty
	a_word_cause: assert property (p_word_cause) else $error("stray word pulse");
	property p_fix;
		s_wr(aig_pkg::OFS_FIX) ##0 regWrData[7] |=> ampGainLeft == $past(regWrData[6:0]);
	endproperty
	a_fix: assert property (p_fix) else $error("fixed gain not applied");
endmodule : aig_regs_checker
bind aig_regs aig_regs_checker chk (.clock, .rst_n, .regAddr, .regWrData, .regWrite, .regRead,
	.regRdData, .fifoCount, .manualFill, .manualWord, .manualWordValid, .ampGainLeft);

// File: bench/aig_front_model.sv
// Behavioural audio front end: sample pacing, level flags and a running sample count.
`timescale 1ns/1ns
module aig_front_model (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic run,
	input wire logic [1:0] level,
	output logic sampleStrobe,
	output logic peakHigh,
	output logic peakLow,
	output logic peakNoise,
	output logic [15:0] count
);
	logic [1:0] gap_r;
	logic [1:0] gap_nxt;
	logic [15:0] count_r;
	logic [15:0] count_nxt;
	// A sample every fourth clock while running; stopping freezes the count for reads.
	always_comb begin
		gap_nxt = run ? gap_r + 2'd1 : 2'd0;
		count_nxt = sampleStrobe ? count_r + 16'h0001 : count_r;
	end
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			gap_r <= 2'd0;
			count_r <= 16'h0000;
		end else begin
			gap_r <= gap_nxt;
			count_r <= count_nxt;
		end
	end
	// Only one level flag is high at a time, as a real detector reports one verdict.
	assign sampleStrobe = run && gap_r == 2'd3;
	assign peakHigh = level == 2'd1;
	assign peakLow = level == 2'd2;
	assign peakNoise = level == 2'd3;
	assign count = count_r;
endmodule : aig_front_model

// File: bench/tb.sv
// Self-checking bench for the audio input gain control register bank.
`timescale 1ns/1ns
module tb;
	// Rows are {write, address, data}: a write row stores, a read row expects the data.
	localparam logic [20:0] ROWS [43] = '{21'h0b2c00, 21'h0b3509, 21'h0b3600, 21'h0b3700,
		21'h0b40fb, 21'h0b4120, 21'h0b4220, 21'h0b4333, 21'h0b4460, 21'h0b4640, 21'h0b4802,
		21'h0b5000, 21'h0b5102, 21'h0b540a, 21'h0b55fa, 21'h0b5600, 21'h0b570a, 21'h0b5803,
		21'h0b5908, 21'h0b5a06, 21'h0b5b06, 21'h0b5c06, 21'h0b6040, 21'h0b6380, 21'h0b6400,
		21'h0b3400, 21'h0b2700, 21'h1b3519, 21'h0b3519, 21'h1b36a5, 21'h0b36a5, 21'h1b375a,
		21'h0b375a, 21'h1b40e5, 21'h0b40e5, 21'h1b447f, 21'h0b447f, 21'h1b4501, 21'h0b4500,
		21'h1b5415, 21'h0b5415, 21'h1b5d3c, 21'h0b5d00};
	// Short tick, unit rates, window 2..5 on the left channel, analog auto mode.
	localparam logic [19:0] PROG [11] = '{20'hb5010, 20'hb5100, 20'hb5701, 20'hb5901,
		20'hb5b01, 20'hb4305, 20'hb5603, 20'hb4182, 20'hb6400, 20'hb6200, 20'hb5401};
	// Each phase is {level, gain expected once settled}.
	localparam logic [8:0] PHASE [4] = '{9'h105, 9'h182, 9'h105, 9'h082};
	logic clock = 1'b0;
	logic rst_n = 1'b0;
	logic [11:0] regAddr = 12'h000;
	logic [7:0] regWrData = 8'h00;
	logic regWrite = 1'b0;
	logic regRead = 1'b0;
	logic run = 1'b0;
	logic [1:0] level = 2'd0;
	logic watch = 1'b0;
	logic sawMask = 1'b0;
	logic [7:0] regRdData, got, converterOptions, calMultiplier, calBias, filterControl;
	logic [7:0] levelSettingLeft, levelSettingRight, modeEnables, smoothingCoef, judgeSpeed;
	logic [15:0] tickPeriod, count;
	logic [31:0] manualWord;
	logic [6:0] ampGainLeft, ampGainRight;
	logic manualFill, manualWordValid, ampMuteLeft, ampMuteRight, sampleMask;
	logic sampleStrobe, peakHigh, peakLow, peakNoise;
	int fail_count = 0;
	int comparisons = 0;
	int cycles = 0;
	aig_front_model front (.clock, .rst_n, .run, .level, .sampleStrobe, .peakHigh, .peakLow,
		.peakNoise, .count);
	aig_regs uut (.clock, .rst_n, .regAddr, .regWrData, .regWrite, .regRead, .regRdData,
		.fifoCount(count), .manualFill, .manualWord, .manualWordValid, .converterOptions,
		.calMultiplier, .calBias, .filterControl, .levelSettingLeft,
		.levelSettingRight, .volumeTargets(), .modeEnables, .smoothingCoef, .tickPeriod,
		.judgeSpeed, .sampleStrobe, .peakHigh, .peakLow, .peakNoise,
		.volumeLeft(count[7:0]), .volumeRight(~count[7:0]), .judgeDone(count[1:0]),
		.manualValueLeft(count[6:0]), .manualValueRight(count[14:8]), .ampGainLeft,
		.ampGainRight, .ampMuteLeft, .ampMuteRight, .sampleMask);
	task automatic check(input logic [32:0] g, input logic [32:0] e);
		comparisons++;
		if (g !== e) begin
			fail_count++;
			$display("wrong value at %0t: got %h expected %h", $time, g, e);
		end
	endtask : check
	// One bus cycle; strobes stay driven after their edge until the next bus call changes them.
	task automatic bus(input logic w, input logic r, input logic [11:0] a, input logic [7:0] d);
		regWrite <= w;
		regRead <= r;
		regAddr <= a;
		regWrData <= d;
		@(posedge clock);
	endtask : bus
	task automatic wr(input logic [11:0] a, input logic [7:0] d);
		bus(1'b1, 1'b0, a, d);
	endtask : wr
	// Read data stand only in the cycle after the strobe, so they are taken at that edge.
	task automatic rd(input logic [11:0] a);
		bus(1'b0, 1'b1, a, 8'h00);
		bus(1'b0, 1'b0, a, 8'h00);
		got = regRdData;
	endtask : rd
	task automatic end_of_test;
		$display("comparisons %0d fail_count %0d", comparisons, fail_count);
		if (fail_count == 0 && comparisons > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : end_of_test
	// Free-running system clock.
	initial begin
		forever #25 clock = ~clock;
	end
	// Cuts a hung run short; the planned sequence needs under 7000 cycles.
	always @(posedge clock) begin
		cycles++;
		if (cycles == 20000) begin
			fail_count++;
			end_of_test();
		end
	end
	// In auto mode the gain must never pass the programmed maximum.
	always @(posedge clock) begin
		if (watch) check(ampGainLeft > 7'h05, 1'b0);
		if (sampleMask === 1'b1) sawMask = 1'b1;
	end
	initial begin
		repeat (6) @(posedge clock);
		rst_n <= 1'b1;
		run <= 1'b1;
		for (int i = 0; i < 43; i++) begin
			if (ROWS[i][20]) begin
				wr(ROWS[i][19:8], ROWS[i][7:0]);
			end else begin
				rd(ROWS[i][19:8]);
				check(got, ROWS[i][7:0]);
			end
		end
		check(converterOptions[4], 1'b1);
		check({calMultiplier, calBias, filterControl, modeEnables}, 32'ha55ae515);
		check({levelSettingLeft, levelSettingRight, smoothingCoef, judgeSpeed}, 32'h2020fa40);
		// Manual fill: four bytes, least significant first, then one top-byte write in auto fill.
		run <= 1'b0;
		wr(aig_pkg::OFS_FILL_MODE, 8'h01);
		for (int i = 0; i < 4; i++) begin
			wr(aig_pkg::OFS_WORD_B0 + 12'(i), 8'(17 * i + 17));
		end
		bus(1'b0, 1'b0, 12'h000, 8'h00);
		check({manualWordValid, manualWord}, {1'b1, 32'h44332211});
		wr(aig_pkg::OFS_FILL_MODE, 8'h00);
		wr(aig_pkg::OFS_WORD_B3, 8'h55);
		bus(1'b0, 1'b0, 12'h000, 8'h00);
		check(manualWordValid, 1'b0);
		rd(aig_pkg::OFS_CNT_LO);
		check(got, count[7:0]);
		rd(aig_pkg::OFS_CNT_HI);
		check(got, count[15:8]);
		wr(aig_pkg::OFS_TGT_L, 8'h2a);
		rd(aig_pkg::OFS_TGT_L);
		check(got, {count[0], 7'h2a});
		// Fixed gain, mute and channel swap, written back to back.
		wr(aig_pkg::OFS_FIX, 8'h85);
		wr(aig_pkg::OFS_VAL_L, 8'h80);
		check({ampGainLeft, ampGainRight}, {7'h05, 7'h05});
		wr(aig_pkg::OFS_SWAP, 8'h01);
		check({ampMuteLeft, ampMuteRight}, 2'b10);
		wr(aig_pkg::OFS_FIX, 8'h00);
		check({ampMuteLeft, ampMuteRight}, 2'b01);
		rd(aig_pkg::OFS_VAL_L);
		check(got, {1'b1, count[6:0]});
		foreach (PROG[i]) wr(PROG[i][19:8], PROG[i][7:0]);
		check(tickPeriod, 16'h0010);
		// Drive the stepper up, down on noise, up, down on loud input.
		watch <= 1'b1;
		run <= 1'b1;
		for (int i = 0; i < 4; i++) begin
			level <= PHASE[i][8:7];
			repeat (1600) @(posedge clock);
			check(ampGainLeft, PHASE[i][6:0]);
		end
		rd(aig_pkg::OFS_GSTAT_L);
		check(got, 8'h02);
		rd(aig_pkg::OFS_AMP_A);
		check(got, 8'h02);
		check(sawMask, 1'b1);
		watch <= 1'b0;
		run <= 1'b0;
		wr(aig_pkg::OFS_MODE, 8'h00);
		wr(aig_pkg::OFS_LVL_L, 8'h00);
		rd(aig_pkg::OFS_GSTAT_L);
		check(got, count[7:0]);
		// A second reset in mid-run restores the fixed-gain default.
		rst_n <= 1'b0;
		@(posedge clock);
		check({regRdData, ampGainLeft}, 15'h0000);
		rst_n <= 1'b1;
		rd(aig_pkg::OFS_FIX);
		check(got, 8'h80);
		end_of_test();
	end
endmodule : tb
